// file: datc_chk.sv
// Port level assertion checker for the trigger capture block
`timescale 1ns/1ps
module datc_chk
  import datc_pkg::*;
#(
  parameter int AW = DATC_ADDR_W
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire datc_range_t range_one,
  input wire datc_range_t range_two,
  input wire datc_chsel_t ch_select,
  input wire datc_src_t trig_source,
  input wire logic master_en,
  input wire logic stream_mode,
  input wire logic arm,
  input wire logic soft_trig,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic [2:0] range_sel_one,
  input wire logic [2:0] range_sel_two,
  input wire logic armed,
  input wire logic triggered,
  input wire logic done,
  input wire logic [AW-1:0] wr_count
);
  // ==========================================================================
  // Properties, all on the block clock
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_ARM_TAKEN: assert property (arm && !armed && !triggered |=> armed)
    else $error("arm request not taken");
  AST_SOFT_FIRE: assert property (armed && trig_source == DATC_SRC_SOFT && soft_trig |=> triggered && !armed)
    else $error("software trigger did not start capture");
  AST_PULSE_TWO: assert property ($rose(sync_oe) |=> sync_oe ##1 !sync_oe)
    else $error("line pulse not two clocks wide");
  AST_PULSE_CAUSE: assert property ($rose(sync_oe) |-> $rose(triggered) && master_en)
    else $error("line pulse without own trigger");
  AST_LINE_HIGH: assert property (sync_out)
    else $error("line driver level low");
  AST_RANGE_SEL: assert property ($past(rst_n) && $stable(range_one) && $stable(range_two)
    |-> range_sel_one == range_one && range_sel_two == range_two)
    else $error("range select does not follow setting");
  AST_DONE_HOLD: assert property (done && $past(done) |-> $stable(wr_count))
    else $error("writes after capture stopped");
  AST_NO_FIRE: assert property (!armed [*3] |=> !$rose(triggered))
    else $error("trigger taken while not armed");
  AST_END_DONE: assert property ($fell(triggered) |-> done)
    else $error("capture ended without done");
  AST_RATE_GAP: assert property (triggered && $changed(wr_count) && ch_select == DATC_CH_ONE
    |=> $stable(wr_count) [*4])
    else $error("sample writes closer than one conversion");
  AST_STREAM_GAP: assert property (triggered && $changed(wr_count) && stream_mode
    && ch_select == DATC_CH_ONE |=> $stable(wr_count) [*8])
    else $error("streaming writes too close");
endmodule

bind datc_top datc_chk #(.AW(AW)) u_chk (.clk(clk), .rst_n(rst_n), .range_one(range_one),
  .range_two(range_two), .ch_select(ch_select), .trig_source(trig_source), .master_en(master_en),
  .stream_mode(stream_mode), .arm(arm), .soft_trig(soft_trig), .sync_out(sync_out), .sync_oe(sync_oe),
  .range_sel_one(range_sel_one), .range_sel_two(range_sel_two), .armed(armed), .triggered(triggered),
  .done(done), .wr_count(wr_count));

// file: datc_mem.sv
// Sample memory with registered read data
`timescale 1ns/1ps
module datc_mem
  import datc_pkg::*;
#(
  parameter int WIDTH = DATC_WORD_W,
  parameter int DEPTH = DATC_MEM_DEPTH,
  parameter int AW = DATC_ADDR_W
)(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [WIDTH-1:0] mem [DEPTH]; // Sample words

  initial
  begin
    if (DEPTH > (1 << AW))
    begin
      $error("datc_mem: depth does not fit address width");
    end
  end

  // Write port and registered read port
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// file: datc_peer.sv
// Model of the peer modules and external source on the shared trigger line
`timescale 1ns/1ps
module datc_peer (
  input wire logic clk,
  input wire logic sync_oe,
  input wire logic sync_out,
  output logic sync_in
);
  // Level put on the line by a peer master or an external source
  logic peer_drv = 1'b0;
  // Module driver wins while enabled; the terminated line idles low otherwise
  assign sync_in = sync_oe ? sync_out : peer_drv;
  // Peer master event: a two clock pulse launched just after an edge
  task automatic line_pulse();
    @(posedge clk);
    #1 peer_drv = 1'b1;
    repeat (2) @(posedge clk);
    #1 peer_drv = 1'b0;
  endtask
  // External source moves the line to a level, making an edge
  task automatic line_level(input logic v);
    @(posedge clk);
    #1 peer_drv = v;
  endtask
endmodule

// file: datc_pkg.sv
// Package of constants and types for the dual channel trigger capture block
package datc_pkg;

  // ==========================================================================
  // Widths and counts
  // ==========================================================================
  localparam int DATC_SAMPLE_W = 14;           // Converter sample width
  localparam int DATC_WORD_W = 16;             // Stored word: flag bit and sample
  localparam int DATC_MEM_DEPTH = 16777216;    // Sixteen million samples
  localparam int DATC_ADDR_W = 24;             // Address width for the memory
  localparam int DATC_DIV_MIN = 1;             // Smallest rate divisor
  localparam int DATC_DIV_MAX = 10;            // Largest rate divisor

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int DATC_CLK_MHZ = 50;            // Block clock rate in MHz
  localparam int DATC_REF_MHZ = 10;            // Highest conversion rate in MHz
  localparam int DATC_BASE_DIV = DATC_CLK_MHZ / DATC_REF_MHZ; // Clocks per 10 MHz tick
  localparam int DATC_STREAM_KSPS = 500;       // Streaming limit, thousand samples per second
  localparam int DATC_STREAM_MIN_CYC = (DATC_CLK_MHZ * 1000 + DATC_STREAM_KSPS - 1) / DATC_STREAM_KSPS;
  localparam int DATC_PULSE_CYC = 2;           // Trigger line pulse width in clocks

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [3:0] DATC_DIV_RST = 4'h1;  // Divisor after reset

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [2:0] {
    DATC_RANGE_10V, DATC_RANGE_5V, DATC_RANGE_2V, DATC_RANGE_1V, DATC_RANGE_0P5V,
    DATC_RANGE_ZERO, DATC_RANGE_AC
  } datc_range_t;

  typedef enum logic [1:0] {
    DATC_SRC_LEVEL, DATC_SRC_SYNC_EDGE, DATC_SRC_MASTER, DATC_SRC_SOFT
  } datc_src_t;

  typedef enum logic [1:0] {
    DATC_FLAG_LINE, DATC_FLAG_CMP, DATC_FLAG_SOFT, DATC_FLAG_PERIOD
  } datc_flag_t;

  typedef enum logic [1:0] {
    DATC_CH_ONE, DATC_CH_TWO, DATC_CH_BOTH
  } datc_chsel_t;

endpackage

// file: datc_rate.sv
// Conversion rate divider: one strobe per selected sample period
`timescale 1ns/1ps
module datc_rate
  import datc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] divisor,
  output logic tick_10m,
  output logic sample_stb
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [3:0] base;   // Clocks inside one 10 MHz period
    logic [3:0] decim;  // 10 MHz ticks inside one sample period
    logic tick;         // 10 MHz converter tick
    logic stb;          // Registered sample strobe
  } datc_rate_st_t;

  datc_rate_st_t st_ff;
  datc_rate_st_t nxt_st;
  logic [3:0] div_safe; // Divisor clamped into 1..10

  // Next state: base tick, then decimation of converter samples
  always_comb
  begin
    div_safe = divisor;
    if (divisor < 4'(DATC_DIV_MIN))
    begin
      div_safe = 4'(DATC_DIV_MIN);
    end
    else if (divisor > 4'(DATC_DIV_MAX))
    begin
      div_safe = 4'(DATC_DIV_MAX);
    end
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.stb = 1'b0;
    if (st_ff.base == 4'(DATC_BASE_DIV - 1))
    begin
      nxt_st.base = 4'h0;
      nxt_st.tick = 1'b1;
      if (st_ff.decim >= div_safe - 4'h1)
      begin
        nxt_st.decim = 4'h0;
        nxt_st.stb = 1'b1;
      end
      else
      begin
        nxt_st.decim = st_ff.decim + 4'h1;
      end
    end
    else
    begin
      nxt_st.base = st_ff.base + 4'h1;
    end
  end

  // Registered state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick_10m = st_ff.tick;
  assign sample_stb = st_ff.stb;

endmodule

// file: datc_top.sv
// Acquisition and trigger control for the two channel digitizer
`timescale 1ns/1ps
module datc_top
  import datc_pkg::*;
#(
  parameter int AW = DATC_ADDR_W,
  parameter int DEPTH = DATC_MEM_DEPTH,
  parameter int PERIOD_CYC = 50000  // Periodic flag pulse spacing in clocks
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] rate_div,
  input wire datc_range_t range_one,
  input wire datc_range_t range_two,
  input wire datc_chsel_t ch_select,
  input wire datc_src_t trig_source,
  input wire logic trig_channel,
  input wire logic trig_falling,
  input wire logic [DATC_SAMPLE_W-1:0] trig_level,
  input wire logic master_en,
  input wire logic stream_mode,
  input wire logic [AW-1:0] capture_count,
  input wire logic arm,
  input wire logic soft_trig,
  input wire logic soft_flag,
  input wire datc_flag_t flag_src_one,
  input wire datc_flag_t flag_src_two,
  input wire logic [DATC_SAMPLE_W-1:0] analog_input_one,
  input wire logic [DATC_SAMPLE_W-1:0] analog_input_two,
  input wire logic sync_in,
  input wire logic [AW-1:0] rd_addr,
  output logic sync_out,
  output logic sync_oe,
  output logic [2:0] range_sel_one,
  output logic [2:0] range_sel_two,
  output logic armed,
  output logic triggered,
  output logic done,
  output logic [AW-1:0] wr_count,
  output logic [DATC_WORD_W-1:0] rd_data
);

  initial
  begin
    if (DEPTH > (1 << AW) || PERIOD_CYC < 1)
    begin
      $error("datc_top: parameters out of range");
    end
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum {ST_IDLE, ST_ARMED, ST_CAPTURE, ST_DONE} datc_fsm_t;

  typedef struct packed {
    datc_fsm_t fsm;
    logic [1:0] sync_meta;                 // Sync pin synchroniser
    logic sync_prev;                       // Last synchronised sync level
    logic [DATC_SAMPLE_W-1:0] s1;          // Sampled channel one
    logic [DATC_SAMPLE_W-1:0] s2;          // Sampled channel two
    logic above_prev;                      // Prior threshold comparison
    logic have_prev;                       // A prior comparison exists
    logic [AW-1:0] waddr;                  // Write pointer
    logic [AW-1:0] left;                   // Words still to store
    logic second;                          // Second word of a pair pending
    logic [1:0] pulse;                     // Master pulse length counter
    logic [$clog2(DATC_STREAM_MIN_CYC+1)-1:0] gap; // Streaming spacing counter
    logic [31:0] per_cnt;                  // Periodic flag counter
    logic per_pulse;                       // Periodic flag pulse
    logic soft_seen;                       // Software flag pulse latch
    logic wr_en;                           // Memory write strobe
    logic [DATC_WORD_W-1:0] wdata;         // Memory write word
    logic [2:0] rng1;                      // Registered range one
    logic [2:0] rng2;                      // Registered range two
    logic [AW-1:0] stored;                 // Words stored so far
    logic [DATC_WORD_W-1:0] pair_word;     // Channel two word held for a pair
    logic line_hi;                         // Level driven onto the line
    logic oe;                              // Line driver enable
    logic armed_lvl;                       // Registered armed status
    logic trig_lvl;                        // Registered capture status
    logic done_lvl;                        // Registered done status
  } datc_st_t;

  datc_st_t st_ff;
  datc_st_t nxt_st;
  logic sample_stb; // Sample strobe before the streaming limit
  logic sync_lvl; // Synchronised trigger line level
  logic [DATC_SAMPLE_W-1:0] cmp_sample; // Channel watched by threshold
  logic above; // Comparison result against level
  logic level_hit; // Threshold crossing this sample
  logic edge_hit; // Selected edge on sync line
  logic fire; // Trigger event
  logic keep; // Sample accepted by streaming limit
  logic [DATC_WORD_W-1:0] word_one; // Channel one stored word
  logic [DATC_WORD_W-1:0] word_two; // Channel two stored word

  // ==========================================================================
  // Rate divider and memory
  // ==========================================================================
  datc_rate u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(rate_div),
    .tick_10m(),
    .sample_stb(sample_stb)
  );

  datc_mem #(.WIDTH(DATC_WORD_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .wr_en(st_ff.wr_en),
    .wr_addr(st_ff.waddr),
    .wr_data(st_ff.wdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Flag bit chooser for one channel
  function automatic logic flag_bit(input datc_flag_t src, input logic line, input logic cmp,
                                    input logic sw, input logic per);
    logic r;
    r = line;
    unique case (src)
      DATC_FLAG_LINE: r = line;
      DATC_FLAG_CMP: r = cmp;
      DATC_FLAG_SOFT: r = sw;
      DATC_FLAG_PERIOD: r = per;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Trigger detection and next state
  // ==========================================================================
  always_comb
  begin
    nxt_st = st_ff;
    sync_lvl = st_ff.sync_meta[1];
    nxt_st.sync_meta = {st_ff.sync_meta[0], sync_in}; // Two flip-flop synchroniser
    nxt_st.sync_prev = sync_lvl;
    nxt_st.wr_en = 1'b0;
    nxt_st.rng1 = range_one;
    nxt_st.rng2 = range_two;
    cmp_sample = trig_channel ? st_ff.s2 : st_ff.s1;
    above = cmp_sample >= trig_level;
    level_hit = sample_stb && st_ff.have_prev && (trig_falling ? (st_ff.above_prev && !above)
                                                              : (!st_ff.above_prev && above));
    edge_hit = trig_falling ? (st_ff.sync_prev && !sync_lvl) : (!st_ff.sync_prev && sync_lvl);
    fire = 1'b0;
    unique case (trig_source)
      DATC_SRC_LEVEL: fire = level_hit;
      DATC_SRC_SYNC_EDGE: fire = edge_hit;
      DATC_SRC_MASTER: fire = !st_ff.sync_prev && sync_lvl;
      DATC_SRC_SOFT: fire = soft_trig;
    endcase
    // Streaming paces stores to the rate cap
    keep = sample_stb && (!stream_mode || st_ff.gap == '0);
    // Periodic flag pulse
    nxt_st.per_pulse = 1'b0;
    if (st_ff.per_cnt >= 32'(PERIOD_CYC - 1))
    begin
      nxt_st.per_cnt = '0;
      nxt_st.per_pulse = 1'b1;
    end
    else
    begin
      nxt_st.per_cnt = st_ff.per_cnt + 32'h1;
    end
    // Software flag stays until the next kept sample, set wins over clear
    if (soft_flag)
    begin
      nxt_st.soft_seen = 1'b1;
    end
    else if (keep)
    begin
      nxt_st.soft_seen = 1'b0;
    end
    // Compare flag is the trigger channel against the threshold, for both words
    word_one = {1'b0, flag_bit(flag_src_one, sync_lvl, above, st_ff.soft_seen,
                               st_ff.per_pulse), st_ff.s1};
    word_two = {1'b0, flag_bit(flag_src_two, sync_lvl, above, st_ff.soft_seen,
                               st_ff.per_pulse), st_ff.s2};
    // Converter samples taken on each sample strobe, kept or not
    if (sample_stb)
    begin
      nxt_st.s1 = analog_input_one;
      nxt_st.s2 = analog_input_two;
      nxt_st.above_prev = above;
      nxt_st.have_prev = 1'b1;
    end
    if (sample_stb && stream_mode)
    begin
      nxt_st.gap = (st_ff.gap == '0) ? ($bits(st_ff.gap))'(DATC_STREAM_MIN_CYC / DATC_BASE_DIV - 1)
                                      : st_ff.gap - 1'b1;
    end
    // Master pulse onto the shared line, one per own event
    if (st_ff.pulse != 2'h0)
    begin
      nxt_st.pulse = st_ff.pulse - 2'h1;
    end
    // Capture sequencer
    unique case (st_ff.fsm)
      ST_IDLE, ST_DONE:
      begin
        if (arm)
        begin
          nxt_st.fsm = ST_ARMED;
          nxt_st.waddr = '0;
          nxt_st.second = 1'b0;
          nxt_st.stored = '0;
          nxt_st.left = capture_count;
        end
      end
      ST_ARMED:
      begin
        if (fire)
        begin
          nxt_st.fsm = ST_CAPTURE;
          if (master_en && trig_source != DATC_SRC_MASTER)
          begin
            nxt_st.pulse = 2'(DATC_PULSE_CYC);
          end
        end
      end
      ST_CAPTURE:
      begin
        // Stop on the programmed count or when the memory is full
        if (st_ff.left == '0 || {1'b0, st_ff.stored} >= (AW+1)'(DEPTH))
        begin
          nxt_st.fsm = ST_DONE;
        end
        else if (st_ff.second)
        begin
          // Channel two word of the pair, held since the kept sample
          nxt_st.wr_en = 1'b1;
          nxt_st.wdata = st_ff.pair_word;
          nxt_st.second = 1'b0;
          nxt_st.waddr = st_ff.stored;
          nxt_st.stored = st_ff.stored + 1'b1;
          nxt_st.left = st_ff.left - 1'b1;
        end
        else if (keep)
        begin
          nxt_st.wr_en = 1'b1;
          nxt_st.wdata = (ch_select == DATC_CH_TWO) ? word_two : word_one;
          nxt_st.second = (ch_select == DATC_CH_BOTH);
          nxt_st.pair_word = word_two; // Both words come from one sample strobe
          nxt_st.waddr = st_ff.stored;
          nxt_st.stored = st_ff.stored + 1'b1;
          nxt_st.left = st_ff.left - 1'b1;
        end
      end
    endcase
    // Status outputs are registered copies of the next state
    nxt_st.armed_lvl = (nxt_st.fsm == ST_ARMED);
    nxt_st.trig_lvl = (nxt_st.fsm == ST_CAPTURE);
    nxt_st.done_lvl = (nxt_st.fsm == ST_DONE);
    nxt_st.oe = (nxt_st.pulse != 2'h0);
    nxt_st.line_hi = 1'b1; // The line is only ever driven high
  end

  // Registered state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.line_hi <= 1'b1; // Line level stays high from reset on
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs from flip-flops
  // ==========================================================================
  assign sync_out = st_ff.line_hi;
  assign sync_oe = st_ff.oe;
  assign range_sel_one = st_ff.rng1;
  assign range_sel_two = st_ff.rng2;
  assign armed = st_ff.armed_lvl;
  assign triggered = st_ff.trig_lvl;
  assign done = st_ff.done_lvl;
  assign wr_count = st_ff.stored;

endmodule

// file: dual_adc_trigger_capture_tb_top.sv
// Self-checking testbench for the trigger capture block
`timescale 1ns/1ps
module dual_adc_trigger_capture_tb_top;
  import datc_pkg::*;
  localparam int AW = 10;
  logic clk, rst_n, arm, soft_trig, soft_flag, master_en, stream_mode, trig_channel, trig_falling;
  logic sync_in, sync_out, sync_oe, armed, triggered, done;
  logic [3:0] rate_div;
  datc_range_t range_one, range_two;
  datc_chsel_t ch_select;
  datc_src_t trig_source;
  datc_flag_t flag_src_one, flag_src_two;
  logic [DATC_SAMPLE_W-1:0] trig_level, a_one, a_two;
  logic [2:0] range_sel_one, range_sel_two;
  logic [AW-1:0] capture_count, rd_addr, wr_count;
  logic [DATC_WORD_W-1:0] rd_data;
  integer seed = 32'heb3b; // Fixed seed keeps runs repeatable
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  // ==========================================================================
  // Design, far side model and clock
  // ==========================================================================
  datc_top #(.AW(AW), .DEPTH(1024), .PERIOD_CYC(20)) uut (.clk(clk), .rst_n(rst_n), .rate_div(rate_div),
    .range_one(range_one), .range_two(range_two), .ch_select(ch_select), .trig_source(trig_source),
    .trig_channel(trig_channel), .trig_falling(trig_falling), .trig_level(trig_level),
    .master_en(master_en), .stream_mode(stream_mode), .capture_count(capture_count), .arm(arm),
    .soft_trig(soft_trig), .soft_flag(soft_flag), .flag_src_one(flag_src_one), .flag_src_two(flag_src_two),
    .analog_input_one(a_one), .analog_input_two(a_two), .sync_in(sync_in), .rd_addr(rd_addr),
    .sync_out(sync_out), .sync_oe(sync_oe), .range_sel_one(range_sel_one), .range_sel_two(range_sel_two),
    .armed(armed), .triggered(triggered), .done(done), .wr_count(wr_count), .rd_data(rd_data));
  datc_peer peer (.clk(clk), .sync_oe(sync_oe), .sync_out(sync_out), .sync_in(sync_in));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  // Compare one value and report a difference
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      results();
    end
  end
  // Random value below a bound
  function automatic logic [13:0] rnd(input int m);
    rnd = 14'($unsigned($random(seed)) % m);
  endfunction
  // Expected stored word: spare bit, flag, sample
  function automatic logic [15:0] word(input logic f, input logic [13:0] s);
    word = {1'b0, f, s};
  endfunction
  // ==========================================================================
  // One armed capture from a given source
  // ==========================================================================
  task automatic cap(input datc_src_t src, input logic [3:0] n, input datc_chsel_t chs,
    input logic [AW-1:0] cnt, input logic strm);
    int t, last, k;
    logic [13:0] lo, hi;
    logic [AW-1:0] prev;
    logic f, g;
    lo = rnd(14'h2000);
    hi = 14'h2000 + rnd(14'h1000);
    trig_source = src;
    rate_div = n;
    ch_select = chs;
    capture_count = cnt;
    stream_mode = strm;
    a_one = rnd(16384);
    a_two = rnd(16384);
    if (src == DATC_SRC_LEVEL)
      if (trig_channel) a_two = trig_falling ? hi : lo;
      else a_one = trig_falling ? hi : lo;
    // Let two sample strobes take the starting values before arming
    repeat (DATC_BASE_DIV * 2 * n) @(posedge clk);
    peer.line_level(src == DATC_SRC_SYNC_EDGE && trig_falling);
    @(posedge clk);
    #1 arm = 1'b1;
    @(posedge clk);
    #1 arm = 1'b0;
    check(armed, 1'b1);
    @(posedge clk);
    #1 check(range_sel_one, range_one);
    check(range_sel_two, range_two);
    case (src)
      DATC_SRC_LEVEL:
        if (trig_channel) a_two = trig_falling ? lo : hi;
        else a_one = trig_falling ? lo : hi;
      DATC_SRC_SYNC_EDGE: peer.line_level(!trig_falling);
      DATC_SRC_MASTER: peer.line_pulse();
      default:
      begin
        soft_trig = 1'b1;
        @(posedge clk);
        #1 soft_trig = 1'b0;
        check(triggered, 1'b1);
        check(sync_oe, master_en);
      end
    endcase
    last = -1;
    prev = wr_count;
    for (t = 0; t < 5000 && done !== 1'b1; t++)
    begin
      @(posedge clk);
      #1;
      if (wr_count !== prev && chs != DATC_CH_BOTH)
      begin
        if (last >= 0)
          check(strm ? (t - last >= DATC_STREAM_MIN_CYC) : (t - last == DATC_BASE_DIV * n), 1'b1);
        last = t;
      end
      prev = wr_count;
    end
    check(done, 1'b1);
    check(wr_count, cnt);
    f = (trig_channel ? a_two : a_one) >= trig_level;
    g = flag_src_two == DATC_FLAG_LINE && src == DATC_SRC_SYNC_EDGE && !trig_falling; // Line level in capture
    for (k = 2; k < cnt; k++)
    begin
      rd_addr = k[AW-1:0];
      @(posedge clk);
      #1;
      if (chs == DATC_CH_TWO || (chs == DATC_CH_BOTH && k[0]))
        check(rd_data, word(g, a_two));
      else
        check(rd_data, word(f, a_one));
    end
    soft_trig = 1'b1;
    @(posedge clk);
    #1 soft_trig = 1'b0;
    @(posedge clk);
    #1 check(triggered, 1'b0);
    peer.line_level(1'b0);
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {rst_n, arm, soft_trig, soft_flag, master_en, stream_mode, trig_channel, trig_falling} = 8'h00;
    rate_div = DATC_DIV_RST;
    range_one = DATC_RANGE_10V;
    range_two = DATC_RANGE_10V;
    ch_select = DATC_CH_ONE;
    trig_source = DATC_SRC_SOFT;
    flag_src_one = DATC_FLAG_CMP;
    flag_src_two = DATC_FLAG_SOFT;
    trig_level = 14'h2000;
    a_one = 14'h0000;
    a_two = 14'h0000;
    capture_count = 10'h004;
    rd_addr = 10'h000;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    // Every source, random polarity, all channel modes and ranges
    for (int i = 0; i < 9; i++)
    begin
      range_one = datc_range_t'(i % 7);
      range_two = datc_range_t'(6 - i % 7);
      trig_falling = 1'($random(seed));
      trig_channel = 1'($random(seed));
      flag_src_two = datc_flag_t'((i % 2 == 1) ? DATC_FLAG_LINE : DATC_FLAG_SOFT);
      master_en = (i == 7);
      cap(datc_src_t'(i % 4), (i == 0) ? 4'h1 : (i == 7) ? 4'ha : 4'(1 + rnd(10)),
        datc_chsel_t'(i % 3), 10'(3 + rnd(4)), 1'b0);
      $display("test %0d done", i);
    end
    master_en = 1'b0;
    cap(DATC_SRC_SOFT, 4'h1, DATC_CH_ONE, 10'h003, 1'b1);
    $display("stream test done");
    results();
  end
endmodule
